//--- common/mioc_pkg.sv
`default_nettype none
package mioc_pkg;
   // channel counts per controller variant
   localparam int MAX_CHANNELS = 8;
   localparam int WIDE_CHANNELS = 8;
   localparam int NARROW_CHANNELS = 4;
   localparam int CHAN_W = 3;
   // opcodes presented with each command
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_OUT_ON = 4'h1;
   localparam logic [3:0] OP_OUT_OFF = 4'h2;
   localparam logic [3:0] OP_WAIT_ON = 4'h3;
   localparam logic [3:0] OP_WAIT_OFF = 4'h4;
   localparam logic [3:0] OP_IF_ON = 4'h5;
   localparam logic [3:0] OP_IF_OFF = 4'h6;
   localparam logic [3:0] OP_LINE_ON = 4'h7;
   localparam logic [3:0] OP_LINE_OFF = 4'h8;
   localparam logic [3:0] OP_OTHER = 4'h9;
   // commands skipped by a failed if test
   localparam logic [1:0] IF_SKIP_COUNT = 2'h2;
   localparam logic [7:0] OUT_RESET = 8'h00;
   typedef enum logic [1:0] {ST_RUN, ST_WAIT} mioc_state_t;
endpackage : mioc_pkg
`default_nettype wire

//--- rtl/mioc_chan_sel.sv
`timescale 1ns/10ps
`default_nettype none
// picks one input channel, masking channels absent in the narrow variant
module mioc_chan_sel
   import mioc_pkg::*;
(
   // inputs
   input wire logic [MAX_CHANNELS-1:0] in_lvl,
   input wire logic [CHAN_W-1:0] chan,
   input wire logic narrow,
   // result
   output logic bit_on,
   output logic chan_ok
);
   // absent channels read as inactive and are flagged illegal
   assign chan_ok = !narrow || (chan < CHAN_W'(NARROW_CHANNELS));
   assign bit_on = chan_ok & in_lvl[chan];
endmodule : mioc_chan_sel
`default_nettype wire

//--- rtl/mioc_exec.sv
// Function
// - wide variant offers eight inputs and eight outputs to the commands.
// - narrow variant offers four inputs and four outputs to the same commands.
// - output-on drives named output active; output-off drives it inactive.
// - wait commands stall execution until the named input reaches requested level.
// - if tests run the next two commands when true, else skip both.
// - line tests run rest of line when true, else discard the line rest.
// - vector interrupts are sampled only between executed commands.
// - no interrupt sampling while a wait command stalls execution.
// - everything after a semicolon on a line is comment and ignored.
`timescale 1ns/10ps
`default_nettype none
module mioc_exec
   import mioc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // variant strap: high selects the four-channel controller
   input wire logic NARROW_VARIANT,
   // command issue from the parser
   input wire logic CMD_VALID,
   input wire logic [3:0] CMD_OP,
   input wire logic [CHAN_W-1:0] CMD_CHAN,
   input wire logic CMD_IN_COMMENT,
   input wire logic CMD_END_LINE,
   // discrete channels
   input wire logic [MAX_CHANNELS-1:0] IN_CHAN,
   output logic [MAX_CHANNELS-1:0] OUT_CHAN,
   // status back to the sequencer
   output logic CMD_READY,
   output logic CMD_DONE,
   output logic CMD_SKIPPED,
   output logic IRQ_SAMPLE
);
   // execution state: running or stalled on an input
   mioc_state_t state_q;
   mioc_state_t state_d;
   // output channel levels
   logic [MAX_CHANNELS-1:0] out_q;
   logic [MAX_CHANNELS-1:0] out_d;
   // commands still to be skipped after a failed if test
   logic [1:0] skip_q;
   logic [1:0] skip_d;
   // the rest of the current line is being discarded
   logic line_drop_q;
   logic line_drop_d;
   // pending wait: requested level and channel
   logic [3:0] wait_op_q;
   logic [3:0] wait_op_d;
   logic [CHAN_W-1:0] wait_chan_q;
   logic [CHAN_W-1:0] wait_chan_d;
   // status strobes, registered so every port comes from a flip-flop
   logic done_q;
   logic done_d;
   logic skipped_q;
   logic skipped_d;
   logic sample_q;
   logic sample_d;
   logic ready_q;
   logic ready_d;
   // selector results
   logic bit_on;
   logic chan_ok;
   logic wbit_on;
   logic wchan_ok;
   // while stalled the selector watches the awaited channel, not the command bus
   wire logic [CHAN_W-1:0] sel_chan = (state_q == ST_WAIT) ? wait_chan_q : CMD_CHAN;
   wire logic [MAX_CHANNELS-1:0] chan_mask;

   // level test for the command or the pending wait
   mioc_chan_sel u_sel
   (
      .in_lvl(IN_CHAN),
      .chan(sel_chan),
      .narrow(NARROW_VARIANT),
      .bit_on(bit_on),
      .chan_ok(chan_ok)
   );
   assign wbit_on = bit_on;
   assign wchan_ok = chan_ok;

   // one-hot of an output channel number
   function automatic logic [MAX_CHANNELS-1:0] onehot(input logic [CHAN_W-1:0] c);
      onehot = MAX_CHANNELS'(1) << c;
   endfunction : onehot

   // true for the test opcodes whose condition asks for an active input
   function automatic logic wants_active(input logic [3:0] op);
      wants_active = (op == OP_WAIT_ON) || (op == OP_IF_ON) || (op == OP_LINE_ON);
   endfunction : wants_active

   assign chan_mask = onehot(CMD_CHAN);

   // command acceptance and suppression
   wire logic take = CMD_VALID && (state_q == ST_RUN);
   wire logic is_comment = CMD_IN_COMMENT;
   wire logic skip_busy = (skip_q != 2'h0);
   wire logic suppressed = skip_busy || line_drop_q;
   wire logic live = take && !is_comment && !suppressed;

   // opcode classes
   wire logic is_out_on = (CMD_OP == OP_OUT_ON);
   wire logic is_out_off = (CMD_OP == OP_OUT_OFF);
   wire logic is_wait = (CMD_OP == OP_WAIT_ON) || (CMD_OP == OP_WAIT_OFF);
   wire logic is_if = (CMD_OP == OP_IF_ON) || (CMD_OP == OP_IF_OFF);
   wire logic is_line = (CMD_OP == OP_LINE_ON) || (CMD_OP == OP_LINE_OFF);

   // condition tests; an absent channel never satisfies a test
   wire logic want_on = wants_active(CMD_OP);
   wire logic cond_ok = chan_ok && (bit_on == want_on);
   wire logic wait_want = wants_active(wait_op_q);
   wire logic wait_met = (state_q == ST_WAIT) && wchan_ok && (wbit_on == wait_want);
   // a wait already met when taken does not stall at all
   wire logic enter_wait = live && is_wait && !cond_ok;

   // execution state machine
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
         begin
            if (enter_wait)
               state_d = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (wait_met)
               state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   // output channel updates; absent channels are left alone
   always_comb
   begin
      out_d = out_q;
      if (live && chan_ok && is_out_on)
         out_d = out_q | chan_mask;
      if (live && chan_ok && is_out_off)
         out_d = out_q & ~chan_mask;
   end

   // if-test skip counter; comment text does not use up a skip
   always_comb
   begin
      skip_d = skip_q;
      if (take && !is_comment && skip_busy)
         skip_d = skip_q - 2'h1;
      if (live && is_if && !cond_ok)
         skip_d = IF_SKIP_COUNT;
   end

   // line discard, cleared by the last command of the line
   always_comb
   begin
      line_drop_d = line_drop_q;
      if (take && CMD_END_LINE)
         line_drop_d = 1'b0;
      if (live && is_line && !cond_ok && !CMD_END_LINE)
         line_drop_d = 1'b1;
   end

   // capture of the awaited level and channel
   always_comb
   begin
      wait_op_d = wait_op_q;
      wait_chan_d = wait_chan_q;
      if (enter_wait)
      begin
         wait_op_d = CMD_OP;
         wait_chan_d = CMD_CHAN;
      end
   end

   // status strobes; interrupts are sampled only after an executed command
   assign done_d = (take && (state_d == ST_RUN)) || wait_met;
   assign skipped_d = take && (is_comment || suppressed);
   assign sample_d = (live && (state_d == ST_RUN)) || wait_met;
   assign ready_d = (state_d == ST_RUN);

   // state and outputs; outputs clear on reset and otherwise hold
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_q <= ST_RUN;
         out_q <= OUT_RESET;
      end
      else
      begin
         state_q <= state_d;
         out_q <= out_d;
      end
   end

   // suppression state
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         skip_q <= 2'h0;
         line_drop_q <= 1'b0;
      end
      else
      begin
         skip_q <= skip_d;
         line_drop_q <= line_drop_d;
      end
   end

   // pending wait
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         wait_op_q <= OP_NOP;
         wait_chan_q <= '0;
      end
      else
      begin
         wait_op_q <= wait_op_d;
         wait_chan_q <= wait_chan_d;
      end
   end

   // handshake and interrupt sampling strobes
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         done_q <= 1'b0;
         skipped_q <= 1'b0;
         sample_q <= 1'b0;
         ready_q <= 1'b0;
      end
      else
      begin
         done_q <= done_d;
         skipped_q <= skipped_d;
         sample_q <= sample_d;
         ready_q <= ready_d;
      end
   end

   // ports straight from the registers
   assign OUT_CHAN = out_q;
   assign CMD_READY = ready_q;
   assign CMD_DONE = done_q;
   assign CMD_SKIPPED = skipped_q;
   assign IRQ_SAMPLE = sample_q;
endmodule : mioc_exec
`default_nettype wire

//--- dv/mioc_exec_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mioc_exec_chk
   import mioc_pkg::*;
(
   // watched ports, grouped to keep the file short
   input wire logic CLK, SYS_RST, NARROW_VARIANT, CMD_VALID, CMD_IN_COMMENT, CMD_END_LINE,
   input wire logic [3:0] CMD_OP,
   input wire logic [CHAN_W-1:0] CMD_CHAN,
   input wire logic [MAX_CHANNELS-1:0] IN_CHAN, OUT_CHAN,
   input wire logic CMD_READY, CMD_DONE, CMD_SKIPPED, IRQ_SAMPLE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // a taken command that is not comment text
   wire tk = CMD_VALID && CMD_READY && !CMD_IN_COMMENT;
   // the reset release also raises ready, so it is kept out
   sequence s_stall; !CMD_READY && !$past(SYS_RST) ##1 CMD_READY; endsequence
   sequence s_dead; tk && CMD_OP == OP_LINE_ON && !IN_CHAN[CMD_CHAN] && !CMD_END_LINE ##1 tk;
   endsequence
   property p_on; tk && CMD_OP == OP_OUT_ON |=> CMD_SKIPPED || OUT_CHAN[$past(CMD_CHAN)]
      || (NARROW_VARIANT && $past(CMD_CHAN) >= CHAN_W'(NARROW_CHANNELS)); endproperty
   property p_off; tk && CMD_OP == OP_OUT_OFF |=> CMD_SKIPPED || !OUT_CHAN[$past(CMD_CHAN)];
   endproperty
   property p_hold; !CMD_VALID |=> $stable(OUT_CHAN); endproperty
   property p_nar; NARROW_VARIANT |-> OUT_CHAN[7:4] == 4'h0; endproperty
   property p_irq; IRQ_SAMPLE |-> CMD_DONE; endproperty
   property p_stall; !CMD_READY |-> !IRQ_SAMPLE && !CMD_DONE; endproperty
   property p_resume; s_stall |-> CMD_DONE && IRQ_SAMPLE; endproperty
   property p_cmt; CMD_VALID && CMD_READY && CMD_IN_COMMENT |=> CMD_SKIPPED; endproperty
   property p_line; s_dead |=> CMD_SKIPPED; endproperty
   a_on: assert property (p_on) else $error("output on lost");
   a_off: assert property (p_off) else $error("output off lost");
   a_hold: assert property (p_hold) else $error("output moved");
   a_nar: assert property (p_nar) else $error("absent output on");
   a_irq: assert property (p_irq) else $error("stray irq sample");
   a_stall: assert property (p_stall) else $error("activity in stall");
   a_resume: assert property (p_resume) else $error("bad wait end");
   a_cmt: assert property (p_cmt) else $error("comment run");
   a_line: assert property (p_line) else $error("line rest run");
endmodule : mioc_exec_chk
bind mioc_exec mioc_exec_chk u_chk
(
   .CLK(CLK),
   .SYS_RST(SYS_RST),
   .NARROW_VARIANT(NARROW_VARIANT),
   .CMD_VALID(CMD_VALID),
   .CMD_IN_COMMENT(CMD_IN_COMMENT),
   .CMD_END_LINE(CMD_END_LINE),
   .CMD_OP(CMD_OP),
   .CMD_CHAN(CMD_CHAN),
   .IN_CHAN(IN_CHAN),
   .OUT_CHAN(OUT_CHAN),
   .CMD_READY(CMD_READY),
   .CMD_DONE(CMD_DONE),
   .CMD_SKIPPED(CMD_SKIPPED),
   .IRQ_SAMPLE(IRQ_SAMPLE)
);
`default_nettype wire

//--- dv/mioc_plc.sv
`timescale 1ns/10ps
`default_nettype none
// far side: relays wired back from the outputs plus push buttons
module mioc_plc
(
   input wire logic CLK,
   input wire logic [7:0] OUT_CHAN,
   input wire logic [7:0] press,
   output logic [7:0] IN_CHAN
);
   // one clock of relay delay, so a wait really has to stall
   always_ff @(posedge CLK) IN_CHAN <= OUT_CHAN | press;
endmodule : mioc_plc
`default_nettype wire

//--- dv/tb_mioc_exec.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mioc_exec;
   import mioc_pkg::*;
   logic CLK = 0, SYS_RST = 1, NARROW_VARIANT = 0, CMD_VALID = 0, CMD_IN_COMMENT = 0;
   logic CMD_END_LINE = 0;
   logic [3:0] CMD_OP = 4'h0;
   logic [2:0] CMD_CHAN = 3'h0;
   logic [7:0] press = 8'h00;
   wire logic [7:0] IN_CHAN, OUT_CHAN;
   wire logic CMD_READY, CMD_DONE, CMD_SKIPPED, IRQ_SAMPLE;
   int errors = 0, comparisons = 0;
   mioc_exec DUT
   (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .NARROW_VARIANT(NARROW_VARIANT),
      .CMD_VALID(CMD_VALID),
      .CMD_OP(CMD_OP),
      .CMD_CHAN(CMD_CHAN),
      .CMD_IN_COMMENT(CMD_IN_COMMENT),
      .CMD_END_LINE(CMD_END_LINE),
      .IN_CHAN(IN_CHAN),
      .OUT_CHAN(OUT_CHAN),
      .CMD_READY(CMD_READY),
      .CMD_DONE(CMD_DONE),
      .CMD_SKIPPED(CMD_SKIPPED),
      .IRQ_SAMPLE(IRQ_SAMPLE)
   );
   mioc_plc u_plc
   (
      .CLK(CLK),
      .OUT_CHAN(OUT_CHAN),
      .press(press),
      .IN_CHAN(IN_CHAN)
   );
   always #25 CLK = ~CLK;
   task test_done;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task chk(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // inputs move 1 ns after the edge so sampling never races them
   task cmd(input logic [3:0] op, input int ch, input logic cm = 0, el = 0);
      @(posedge CLK);
      #1;
      CMD_VALID = 1;
      CMD_OP = op;
      CMD_CHAN = ch[2:0];
      CMD_IN_COMMENT = cm;
      CMD_END_LINE = el;
   endtask : cmd
   // let the last offer be taken, then withdraw it
   task idle;
      @(posedge CLK);
      #1;
      CMD_VALID = 0;
      CMD_OP = OP_NOP;
   endtask : idle
   task rst(input logic nv);
      SYS_RST = 1;
      NARROW_VARIANT = nv;
      repeat (6) @(posedge CLK);
      #1;
      SYS_RST = 0;
      chk(OUT_CHAN, 8'h00);
      @(posedge CLK);
   endtask : rst
   task s_out;
      for (int i = 0; i < 8; i++) cmd(OP_OUT_ON, i);
      cmd(OP_OUT_OFF, 3);
      idle;
      chk(OUT_CHAN, 8'hF7);
   endtask : s_out
   // stall on input 3, then let the button release it
   task wt(input logic [3:0] op, input logic lvl);
      int n;
      press[3] = lvl;
      cmd(op, 3);
      idle;
      repeat (4) @(posedge CLK);
      #1;
      chk({CMD_READY, IRQ_SAMPLE}, 8'h00);
      press[3] = !lvl;
      n = 0;
      while (CMD_DONE !== 1'b1 && n < 10)
      begin
         @(posedge CLK);
         #1;
         n++;
      end
      chk({n[4:0], CMD_READY, IRQ_SAMPLE}, 8'h0B);
      if (n == 10) test_done;
   endtask : wt
   // failed if skips two, the comment does not count
   task s_if;
      cmd(OP_IF_OFF, 0);
      cmd(OP_OUT_OFF, 6, 1);
      cmd(OP_OUT_OFF, 1);
      chk({CMD_SKIPPED, IRQ_SAMPLE}, 8'h02);
      cmd(OP_OUT_OFF, 2);
      cmd(OP_OUT_OFF, 4);
      cmd(OP_IF_ON, 0);
      cmd(OP_OUT_OFF, 5);
      idle;
      chk(OUT_CHAN, 8'hC7);
   endtask : s_if
   task s_line;
      cmd(OP_LINE_ON, 3);
      cmd(OP_OUT_OFF, 0);
      cmd(OP_OUT_OFF, 1, 0, 1);
      cmd(OP_OUT_OFF, 2);
      cmd(OP_LINE_OFF, 3);
      cmd(OP_OUT_OFF, 6, 0, 1);
      idle;
      chk(OUT_CHAN, 8'h83);
   endtask : s_line
   task s_narrow;
      rst(1);
      cmd(OP_OUT_ON, 7);
      cmd(OP_OUT_ON, 1);
      idle;
      chk(OUT_CHAN, 8'h02);
   endtask : s_narrow
   initial
   begin
      rst(0);
      s_out;
      wt(OP_WAIT_ON, 0);
      wt(OP_WAIT_OFF, 1);
      s_if;
      s_line;
      s_narrow;
      test_done;
   end
endmodule : tb_mioc_exec
`default_nettype wire
